// *** uart_top.v ***
// UART with baud generator, frame format, data buffer and AXI4-Lite slave
//
// Operation
// RULE1: Bit timing from free-running 8-bit timer
// RULE2: Rate is clock over 64 or 16 times N+1
// RULE3: Divisor takes any value 0 to 255
// RULE4: One data location: write sends, read receives
// RULE5: Frame: start, 8/9 data bits, 1/2 two_stop_select
// RULE6: Even, odd or no parity; format bits select
// RULE7: Parity replaces top bit of data field
// RULE8: Top data bit may mark address character
// RULE9: Reset default eight bits, no parity, one stop
// RULE10: Both directions shift LSB first
// RULE11: Independent directions share format and rate
// RULE12: One or two two_stop_select, independent of length
// RULE13: Pins taken only when all enables set; code takes each pin with master enable and its own direction enable only
// RULE14: TX line high when no frame sent
// RULE15: Master disable frees pins, empties buffers
// RULE16: Disable clears enables, flags; sets idle flags
// RULE17: Disable leaves other control and divisor alone
// RULE18: Disable aborts at once; re-enable resumes config
// RULE19: Receiver oversamples 16x, three-sample majority
// RULE20: Timer reloads divisor at each terminal count
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "uart_map.vh"

module uart_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        rx_in,
	output reg         tx_out,
	output reg         tx_oe,
	output reg         rx_owned
);

	localparam T_IDLE  = 2'h0;
	localparam T_START = 2'h1;
	localparam T_DATA  = 2'h2;
	localparam T_STOP  = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	reg  [7:0]  divisor_q;
	reg  [7:0]  ctl1_q;
	reg  [7:0]  ctl2_q;
	reg  [7:0]  status_q;
	reg  [7:0]  tx_hold_q;
	reg         tx_hold8_q;
	reg  [8:0]  rx_buf_q;
	reg  [1:0]  tstate_q;
	reg  [3:0]  tsub_q;
	reg  [3:0]  tbits_q;
	reg  [8:0]  tsh_q;
	reg         tbrk_q;
	reg         tstop2_q;
	reg         aw_got_q;
	reg         w_got_q;
	reg  [31:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg  [7:0]  rd_mux;
	reg         rd_hit;
	reg  [8:0]  tx_field;

	wire        aw_hs;
	wire        w_hs;
	wire        ar_hs;
	wire        do_wr;
	wire [31:0] wr_addr;
	wire [31:0] wr_data;
	wire        wr_lane;
	wire        wr_hit;
	wire        wr_data_reg;
	wire        rd_data_reg;
	wire        master_en;
	wire        tx_run;
	wire        rx_run;
	wire        nine;
	wire        par_en;
	wire        par_odd;
	wire        os_tick;
	wire        bit_end;
	wire        rx_done;
	wire [8:0]  rx_data;
	wire        rx_framing_error_flag;
	wire        rx_parity_error_flag;
	wire        rx_noise;
	wire        rx_idle;
	wire        tx_load;
	wire        tx_frame_end;

	////////////////////////////////////////////////////////////////////////
	// Shared format and enables

	assign master_en = ctl1_q[`C1_MASTER_EN];
	// Pins belong to the UART only with master and direction enables
	assign tx_run    = master_en & ctl2_q[`C2_TX_EN]; // [RULE13]
	assign rx_run    = master_en & ctl2_q[`C2_RX_EN]; // [RULE13]
	// One format for both directions
	assign nine      = ctl1_q[`C1_NINE_BIT]; // [RULE11]
	assign par_en    = ctl1_q[`C1_PARITY_EN];
	assign par_odd   = ctl1_q[`C1_PARITY_TYPE];

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	assign aw_hs       = s_axi_awvalid & s_axi_awready;
	assign w_hs        = s_axi_wvalid & s_axi_wready;
	assign ar_hs       = s_axi_arvalid & s_axi_arready;
	assign do_wr       = (aw_got_q | aw_hs) & (w_got_q | w_hs) & !s_axi_bvalid;
	assign wr_addr     = aw_got_q ? awaddr_q : s_axi_awaddr;
	assign wr_data     = w_got_q ? wdata_q : s_axi_wdata;
	assign wr_lane     = w_got_q ? wstrb_q[0] : s_axi_wstrb[0];
	assign wr_hit      = (wr_addr[31:5] == 27'h0) && (wr_addr[1:0] == 2'h0) &&
	                     (wr_addr[7:0] <= `STATUS_OFS);
	assign wr_data_reg = do_wr & wr_lane & wr_hit &
	                     (wr_addr[7:0] == `DATA_BUFFER_OFS);
	assign rd_data_reg = ar_hs &
	                     (s_axi_araddr == {24'h0, `DATA_BUFFER_OFS});

	// Channel ready and response flags
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= 32'h0;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
		end else begin
			if (aw_hs) begin
				s_axi_awready <= 1'b0;
				awaddr_q      <= s_axi_awaddr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
			if (do_wr) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (aw_hs)
					aw_got_q <= 1'b1;
				if (w_hs)
					w_got_q <= 1'b1;
				if (s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read mux; unmapped offsets read zero with an error response
	always @* begin
		rd_mux = 8'h00;
		rd_hit = 1'b1;
		case (s_axi_araddr)
		{24'h0, `DATA_BUFFER_OFS}:  rd_mux = rx_buf_q[7:0]; // [RULE4]
		{24'h0, `BAUD_DIVISOR_OFS}: rd_mux = divisor_q;
		{24'h0, `CONTROL_ONE_OFS}:  rd_mux = ctl1_q;
		{24'h0, `CONTROL_TWO_OFS}:  rd_mux = ctl2_q;
		{24'h0, `STATUS_OFS}:       rd_mux = status_q;
		default:                    rd_hit = 1'b0;
		endcase
	end

	// Read channel; one read at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h0, rd_mux};
			s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Disable clears only enables and break; the rest is kept
	always @(posedge aclk) begin
		if (!aresetn) begin
			divisor_q <= `DIVISOR_RST;
			ctl1_q    <= `CONTROL_RST; // [RULE9]
			ctl2_q    <= `CONTROL_RST;
		end else begin
			if (do_wr && wr_lane && wr_hit) begin
				case (wr_addr[7:0])
				`BAUD_DIVISOR_OFS: divisor_q <= wr_data[7:0]; // [RULE3]
				`CONTROL_ONE_OFS:
					ctl1_q <= {wr_data[7:2], ctl1_q[1], wr_data[0]};
				`CONTROL_TWO_OFS:  ctl2_q <= wr_data[7:0];
				default: ;
				endcase
			end
			// Received ninth bit shows in control one
			if (rx_done && !status_q[`ST_RX_AVAIL])
				ctl1_q[`C1_RX_BIT8] <= rx_data[8];
			if (!master_en) begin
				ctl2_q[`C2_TX_EN] <= 1'b0; // [RULE16] [RULE17]
				ctl2_q[`C2_RX_EN] <= 1'b0; // [RULE16]
				ctl1_q[`C1_BREAK] <= 1'b0; // [RULE16]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Baud generator and receiver

	// Timer runs while the UART is on; new divisor taken at next reload
	baud_timer u_baud (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.enable     (master_en),
		.high_speed (ctl2_q[`C2_HIGH_SPEED]),
		.divisor    (divisor_q),
		.os_tick    (os_tick)
	);

	uart_receiver u_rx (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.enable     (rx_run),
		.os_tick    (os_tick),
		.rx_in      (rx_in),
		.nine_bit   (nine),
		.parity_en  (par_en),
		.parity_odd (par_odd),
		.done       (rx_done),
		.data       (rx_data),
		.framing_error_flag       (rx_framing_error_flag),
		.parity_error_flag       (rx_parity_error_flag),
		.noise      (rx_noise),
		.idle       (rx_idle)
	);

	////////////////////////////////////////////////////////////////////////
	// Transmitter

	assign bit_end      = os_tick & (tsub_q == `OVERSAMPLE);
	// Frames start on a tick so the start bit is a full sixteen ticks
	assign tx_load      = (tstate_q == T_IDLE) & tx_run & os_tick &
	                      !status_q[`ST_TX_EMPTY];
	assign tx_frame_end = (tstate_q == T_STOP) & bit_end & !tstop2_q;

	// Data field; parity takes the top position when enabled
	always @* begin
		tx_field = {tx_hold8_q, tx_hold_q}; // [RULE8]
		if (nine && par_en)
			tx_field[8] = (^tx_hold_q) ^ par_odd; // [RULE7]
		else if (!nine && par_en)
			tx_field = {1'b0, (^tx_hold_q[6:0]) ^ par_odd, tx_hold_q[6:0]};
		else if (!nine)
			tx_field = {1'b0, tx_hold_q};
	end

	// Frame sequencer; data has priority over a pending break
	always @(posedge aclk) begin
		if (!aresetn || !tx_run) begin
			tstate_q <= T_IDLE; // [RULE18]
			tsub_q   <= 4'h0;
			tbits_q  <= 4'h0;
			tsh_q    <= 9'h000;
			tbrk_q   <= 1'b0;
			tstop2_q <= 1'b0;
		end else begin
			if (tstate_q != T_IDLE && os_tick)
				tsub_q <= tsub_q + 4'h1;
			case (tstate_q)
			T_IDLE: begin
				tsub_q <= 4'h0;
				if (tx_load) begin
					tstate_q <= T_START;
					tsh_q    <= tx_field;
					tbits_q  <= nine ? 4'h9 : 4'h8; // [RULE5]
					tbrk_q   <= 1'b0;
				end else if (ctl1_q[`C1_BREAK] && os_tick) begin
					tstate_q <= T_START;
					tsh_q    <= 9'h000;
					tbits_q  <= `BREAK_BITS;
					tbrk_q   <= 1'b1;
				end
			end
			T_START: begin
				if (bit_end)
					tstate_q <= T_DATA;
			end
			T_DATA: begin
				if (bit_end) begin
					tsh_q   <= {1'b0, tsh_q[8:1]}; // [RULE10]
					tbits_q <= tbits_q - 4'h1;
					if (tbits_q == 4'h1) begin
						if (tbrk_q && ctl1_q[`C1_BREAK]) begin
							tstate_q <= T_START;
							tbits_q  <= `BREAK_BITS;
						end else begin
							tstate_q <= T_STOP;
							tstop2_q <= ctl1_q[`C1_TWO_STOP]; // [RULE12]
						end
					end
				end
			end
			T_STOP: begin
				if (bit_end) begin
					if (tstop2_q)
						tstop2_q <= 1'b0;
					else
						tstate_q <= T_IDLE;
				end
			end
			default: tstate_q <= T_IDLE;
			endcase
		end
	end

	// Pin drive from flops; line sits high between frames
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_out   <= 1'b1;
			tx_oe    <= 1'b0;
			rx_owned <= 1'b0;
		end else begin
			tx_oe    <= tx_run; // [RULE13] [RULE15]
			rx_owned <= rx_run; // [RULE15]
			// A released pin goes high on the same edge as its enable drops
			case (tx_run ? tstate_q : T_IDLE)
			T_START: tx_out <= 1'b0;
			T_DATA:  tx_out <= tsh_q[0];
			default: tx_out <= 1'b1; // [RULE14]
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffers and status flags

	// Hardware sets win over software clears on the same edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			status_q   <= `STATUS_RST;
			tx_hold_q  <= 8'h00;
			tx_hold8_q <= 1'b0;
			rx_buf_q   <= 9'h000;
		end else if (!master_en) begin
			status_q   <= `STATUS_RST; // [RULE15] [RULE16]
			rx_buf_q   <= 9'h000;
		end else begin
			status_q[`ST_RX_IDLE] <= rx_idle;
			// Write only while holding is empty; clears both tx flags
			if (wr_data_reg && status_q[`ST_TX_EMPTY]) begin
				tx_hold_q               <= wr_data[7:0]; // [RULE4]
				tx_hold8_q              <= ctl1_q[`C1_TX_BIT8];
				status_q[`ST_TX_EMPTY]  <= 1'b0;
				status_q[`ST_TX_IDLE]   <= 1'b0;
			end
			if (tx_load)
				status_q[`ST_TX_EMPTY] <= 1'b1;
			if (tx_frame_end && !tbrk_q)
				status_q[`ST_TX_IDLE] <= 1'b1;
			if (!tx_run)
				status_q[`ST_TX_EMPTY] <= 1'b1;
			if (rd_data_reg)
				status_q[`ST_RX_AVAIL] <= 1'b0;
			// Single holding word; a frame landing on a full one is lost
			if (rx_done) begin
				if (status_q[`ST_RX_AVAIL] && !rd_data_reg) begin
					status_q[`ST_OVERRUN] <= 1'b1;
				end else begin
					rx_buf_q               <= rx_data;
					status_q[`ST_RX_AVAIL] <= 1'b1;
					status_q[`ST_FRAMING]  <= rx_framing_error_flag;
					status_q[`ST_PARITY]   <= rx_parity_error_flag;
					status_q[`ST_NOISE]    <= rx_noise;
				end
			end
		end
	end

endmodule // uart_top

// *** uart_map.vh ***
// Register map, field positions, reset values and timing for the UART
`ifndef UART_MAP_VH
`define UART_MAP_VH

// Register byte offsets
`define DATA_BUFFER_OFS   8'h00
`define BAUD_DIVISOR_OFS  8'h04
`define CONTROL_ONE_OFS   8'h08
`define CONTROL_TWO_OFS   8'h0c
`define STATUS_OFS        8'h10

// Control one fields
`define C1_MASTER_EN      7
`define C1_NINE_BIT       6
`define C1_PARITY_EN      5
`define C1_PARITY_TYPE    4
`define C1_TWO_STOP       3
`define C1_BREAK          2
`define C1_RX_BIT8        1
`define C1_TX_BIT8        0

// Control two fields
`define C2_TX_EN          7
`define C2_RX_EN          6
`define C2_HIGH_SPEED     5

// Status fields
`define ST_RX_AVAIL       0
`define ST_OVERRUN        1
`define ST_FRAMING        2
`define ST_PARITY         3
`define ST_NOISE          4
`define ST_TX_IDLE        5
`define ST_TX_EMPTY       6
`define ST_RX_IDLE        7

// Reset values
`define DIVISOR_RST       8'h00
`define CONTROL_RST       8'h00
`define STATUS_RST        8'he0

// Timing
`define OVERSAMPLE        4'hf
`define LOW_SPEED_PRE     2'h3
`define BREAK_BITS        4'hd
`define MID_SAMPLE_A      4'h7
`define MID_SAMPLE_B      4'h8
`define MID_SAMPLE_C      4'h9

// Bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** baud_timer.v ***
// Baud timer producing the sixteen-times oversampling tick
`timescale 1ns/10ps
`include "uart_map.vh"

module baud_timer (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       enable,
	input  wire       high_speed,
	input  wire [7:0] divisor,
	output reg        os_tick
);

	reg  [1:0] pre_q;
	reg  [7:0] timer_q;
	wire       pre_tick;

	// Low speed divides by four more so a bit is 64 clocks per count
	assign pre_tick = high_speed | (pre_q == `LOW_SPEED_PRE); // [RULE2]

	// Free-running 8-bit timer, reloads divisor at terminal count
	always @(posedge aclk) begin
		if (!aresetn || !enable) begin
			pre_q   <= 2'h0;
			timer_q <= 8'h00;
			os_tick <= 1'b0;
		end else begin
			pre_q   <= pre_q + 2'h1;
			os_tick <= 1'b0;
			if (pre_tick) begin
				if (timer_q == 8'h00) begin
					timer_q <= divisor; // [RULE1] [RULE3] [RULE20]
					os_tick <= 1'b1;
				end else begin
					timer_q <= timer_q - 8'h01;
				end
			end
		end
	end

endmodule // baud_timer

// *** uart_receiver.v ***
// Receive shifter with three-sample majority recovery
`timescale 1ns/10ps
`include "uart_map.vh"

module uart_receiver (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       enable,
	input  wire       os_tick,
	input  wire       rx_in,
	input  wire       nine_bit,
	input  wire       parity_en,
	input  wire       parity_odd,
	output reg        done,
	output reg  [8:0] data,
	output reg        framing_error_flag,
	output reg        parity_error_flag,
	output reg        noise,
	output reg        idle
);

	localparam S_IDLE = 1'b0;
	localparam S_BUSY = 1'b1;

	reg        state_q;
	reg  [3:0] sub_q;
	reg  [3:0] bit_q;
	reg  [2:0] smp_q;
	reg  [8:0] sh_q;
	reg        nz_q;
	wire [2:0] s3;
	wire       maj;
	wire [3:0] last;
	wire [8:0] field;
	wire       par_x;

	assign s3    = {smp_q[1:0], rx_in};
	// Majority of three samples at mid-bit
	assign maj   = (s3[0] & s3[1]) | (s3[0] & s3[2]) | (s3[1] & s3[2]); // [RULE19]
	assign last  = nine_bit ? 4'ha : 4'h9;
	// Both lengths fill from the top; eight-bit words end up in bits 8:1
	assign field = {maj, sh_q[8:1]};
	// Bit 0 holds a stale bit in eight-bit mode, so keep it out of parity
	assign par_x = nine_bit ? ^sh_q : ^sh_q[8:1];

	// Start detect, then one bit every sixteen ticks, LSB first
	always @(posedge aclk) begin
		if (!aresetn || !enable) begin
			state_q <= S_IDLE;
			sub_q   <= 4'h0;
			bit_q   <= 4'h0;
			smp_q   <= 3'h0;
			sh_q    <= 9'h000;
			nz_q    <= 1'b0;
			done    <= 1'b0;
			data    <= 9'h000;
			framing_error_flag    <= 1'b0;
			parity_error_flag    <= 1'b0;
			noise   <= 1'b0;
			idle    <= 1'b1;
		end else begin
			done <= 1'b0;
			idle <= (state_q == S_IDLE);
			case (state_q)
			S_IDLE: begin
				if (os_tick && !rx_in) begin
					state_q <= S_BUSY;
					sub_q   <= 4'h1;
					bit_q   <= 4'h0;
					nz_q    <= 1'b0;
				end
			end
			S_BUSY: begin
				if (os_tick) begin
					sub_q <= sub_q + 4'h1;
					if (sub_q == `MID_SAMPLE_A || sub_q == `MID_SAMPLE_B)
						smp_q <= {smp_q[1:0], rx_in};
					if (sub_q == `MID_SAMPLE_C) begin
						if (s3 != 3'h0 && s3 != 3'h7)
							nz_q <= 1'b1;
						if (bit_q == 4'h0 && maj) begin
							state_q <= S_IDLE; // False start
						end else if (bit_q == last) begin
							state_q <= S_IDLE;
							done    <= 1'b1;
							data    <= nine_bit ? sh_q : {1'b0, sh_q[8:1]};
							framing_error_flag    <= !maj; // [RULE12]
							parity_error_flag    <= parity_en & (par_x ^ parity_odd); // [RULE6]
							noise   <= nz_q | (s3 != 3'h0 && s3 != 3'h7);
						end else if (bit_q != 4'h0) begin
							sh_q <= field; // [RULE10]
						end
					end
					if (sub_q == `OVERSAMPLE)
						bit_q <= bit_q + 4'h1;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

endmodule // uart_receiver

// *** uart_top_chk.sv ***
// Port-level assertions for the UART top module
`timescale 1ns/10ps
module uart_top_chk (
	input wire        aclk,
	input wire        aresetn,
	input wire        tx_out,
	input wire        tx_oe,
	input wire        rx_owned,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire [31:0] s_axi_rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [15:0] low_q;
	// Low run on the line; wraps on a multiple of 16, so long breaks stay legal
	always @(posedge aclk)
		if (!aresetn) low_q <= 16'h0;
		else low_q <= tx_out ? 16'h0 : low_q + 16'h1;
	////////////////////////////////////////////////////////////////////////
	property p_free_high; !tx_oe |-> tx_out; endproperty
	property p_fall_owned; $fell(tx_out) |-> tx_oe; endproperty
	// Pin ownership only moves as a register write completes
	property p_oe_by_write;
		$changed(tx_oe) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	property p_own_by_write;
		$changed(rx_owned) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	// Every low run ending inside an owned frame is a nonzero multiple of 16 clocks
	property p_bit_len;
		$rose(tx_out) && tx_oe && $past(tx_oe)
			|-> low_q[3:0] == 4'h0 && low_q != 16'h0;
	endproperty
	property p_high_min; $rose(tx_out) |-> tx_out [*8]; endproperty
	property p_rd_zero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> s_axi_bvalid;
	endproperty
	a_free_high: assert property (p_free_high)
		else $error("tx low while pin is free");
	a_fall_owned: assert property (p_fall_owned)
		else $error("frame started on a free pin");
	a_oe_by_write: assert property (p_oe_by_write)
		else $error("tx ownership moved without a write");
	a_own_by_write: assert property (p_own_by_write)
		else $error("rx ownership moved without a write");
	a_bit_len: assert property (p_bit_len)
		else $error("low run not whole bits");
	a_high_min: assert property (p_high_min)
		else $error("high level shorter than a bit");
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data upper bits set");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer late");
	c_frame: cover property ($fell(tx_out));
	c_owned: cover property ($rose(tx_oe));
	c_read: cover property (s_axi_rvalid);
endmodule // uart_top_chk

bind uart_top uart_top_chk i_chk (.aclk(aclk), .aresetn(aresetn),
	.tx_out(tx_out), .tx_oe(tx_oe), .rx_owned(rx_owned),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata));

// *** serial_peer.sv ***
// Serial peer: decodes frames from the UART and sends frames into it
`timescale 1ns/10ps
module serial_peer (
	input  wire  aclk,
	input  wire  tx_out,
	input  wire  tx_oe,
	input  int   bit_clks,
	input  int   nbits,
	input  int   nstop,
	output logic rx_line
);
	logic [8:0] rx_word;
	logic       stop_ok;
	int         rx_count;
	int         run;
	int         last_run;
	initial begin
		rx_line = 1'b1;
		rx_count = 0;
		run = 0;
		last_run = 0;
	end
	// Length of the latest low run, one bit time when a word ends in 10
	always @(posedge aclk)
		if (!tx_out) run <= run + 1;
		else if (run != 0) begin
			last_run <= run;
			run <= 0;
		end
	////////////////////////////////////////////////////////////////////////
	// Mid-bit decode; trails the line by half a bit, so rates must not drift
	always begin
		@(negedge tx_out);
		if (tx_oe) begin
			repeat (bit_clks / 2) @(posedge aclk);
			rx_word = 9'h0;
			stop_ok = 1'b1;
			for (int i = 0; i < nbits; i++) begin
				repeat (bit_clks) @(posedge aclk);
				rx_word[i] = tx_out;
			end
			for (int i = 0; i < nstop; i++) begin
				repeat (bit_clks) @(posedge aclk);
				if (!tx_out) stop_ok = 1'b0;
			end
			rx_count++;
		end
	end
	// Drive one frame; the line rests high between frames
	task send(input logic [8:0] w, input int nb, input int ns);
		@(posedge aclk);
		rx_line <= 1'b0;
		repeat (bit_clks) @(posedge aclk);
		for (int i = 0; i < nb; i++) begin
			rx_line <= w[i];
			repeat (bit_clks) @(posedge aclk);
		end
		rx_line <= 1'b1;
		repeat (bit_clks * ns) @(posedge aclk);
	endtask
endmodule // serial_peer

// *** tb_top.sv ***
// Self-checking bench: registers, framing, rates, disable and resume
`timescale 1ns/10ps
`include "uart_map.vh"
module tb_top;
	logic        aclk, aresetn, awv, wv, bready, arv, rready;
	logic [31:0] awaddr, wdata, araddr, d;
	logic [3:0]  wstrb;
	logic [1:0]  r;
	wire         awr, wrr, bv, arr, rv, tx_out, tx_oe, rx_owned, rx_line;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          bit_clks, nbits, nstop, bad_count, checks_done;
	logic [7:0]  div_t [3] = '{8'h00, 8'h02, 8'h01};
	logic [7:0]  ctl_t [3] = '{8'he0, 8'he0, 8'hc0};
	int          len_t [3] = '{16, 48, 128};
	uart_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rready), .rx_in(rx_line), .tx_out(tx_out),
		.tx_oe(tx_oe), .rx_owned(rx_owned));
	serial_peer i_peer (.aclk(aclk), .tx_out(tx_out), .tx_oe(tx_oe),
		.bit_clks(bit_clks), .nbits(nbits), .nstop(nstop), .rx_line(rx_line));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t value %h want %h", $time, got, exp);
		end
	endtask
	task chk_pin(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t pin %b want %b", $time, got, exp);
		end
	endtask
	// Write one register; each channel drops once it is taken
	task wr(input logic [7:0] a, input logic [7:0] v);
		int n;
		logic [1:0] e;
		n = 0;
		e = (a > `STATUS_OFS) ? `RESP_SLVERR : `RESP_OKAY;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrr) wv <= 1'b0;
			n++;
		end while (!bv && n < 200);
		if (!bv) bad_count++;
		chk_val({30'h0, bresp}, {30'h0, e});
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= {24'h0, a};
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'b0;
			n++;
		end while (!rv && n < 200);
		if (!rv) bad_count++;
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk_val(d, {24'h0, e});
		chk_val({30'h0, r}, {30'h0, `RESP_OKAY});
	endtask
	// Send through the data register and compare the peer's decode
	task tx_chk(input logic [7:0] v, input logic [8:0] e);
		int n0;
		int n;
		n0 = i_peer.rx_count;
		n = 0;
		wr(`DATA_BUFFER_OFS, v);
		while (i_peer.rx_count == n0 && n < 4000) begin
			@(posedge aclk);
			n++;
		end
		if (i_peer.rx_count == n0) bad_count++;
		chk_val({23'h0, i_peer.rx_word}, {23'h0, e});
		chk_pin(i_peer.stop_ok, 1'b1);
	endtask
	task give_verdict;
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge aclk);
		bad_count++;
		give_verdict;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, awv, wv, bready, arv, rready} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'h1;
		{bit_clks, nbits, nstop} = {32'd16, 32'd8, 32'd1};
		{bad_count, checks_done} = 64'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`CONTROL_ONE_OFS, 8'h00);
		rchk(8'h10, 8'he0);
		chk_pin(tx_out, 1'b1);
		// Enables are refused while the master enable is off
		wr(`CONTROL_TWO_OFS, 8'he0);
		rchk(`CONTROL_TWO_OFS, 8'h20);
		rd(8'h20);
		chk_val(d, 32'h0);
		chk_val({30'h0, r}, {30'h0, `RESP_SLVERR});
		wr(8'h20, 8'h55);
		wr(`BAUD_DIVISOR_OFS, 8'hff);
		rchk(`BAUD_DIVISOR_OFS, 8'hff);
		wr(`CONTROL_ONE_OFS, 8'h80);
		wr(`CONTROL_TWO_OFS, 8'he0);
		repeat (3) @(negedge aclk);
		chk_pin(tx_oe & rx_owned, 1'b1);
		// Bit time over speed select and divisor, on words ending in 10
		for (int k = 0; k < 3; k++) begin
			wr(`BAUD_DIVISOR_OFS, div_t[k]);
			wr(`CONTROL_TWO_OFS, ctl_t[k]);
			bit_clks = len_t[k];
			tx_chk(8'ha5, 9'h0a5);
			chk_val(i_peer.last_run, len_t[k]);
		end
		wr(`BAUD_DIVISOR_OFS, 8'h01);
		wr(`CONTROL_TWO_OFS, 8'he0);
		bit_clks = 32;
		// Parity takes the top field bit: even, then odd
		for (int k = 0; k < 2; k++) begin
			wr(`CONTROL_ONE_OFS, k ? 8'hb0 : 8'ha0);
			tx_chk(8'h13, k ? 9'h013 : 9'h093);
		end
		wr(`CONTROL_ONE_OFS, 8'hc9);
		{nbits, nstop} = {32'd9, 32'd2};
		tx_chk(8'h5a, 9'h15a);
		// Both directions at once on one format and rate
		wr(`CONTROL_ONE_OFS, 8'h88);
		nbits = 8;
		fork
			tx_chk(8'h81, 9'h081);
			i_peer.send(9'h03c, 8, 1);
		join
		repeat (60) @(posedge aclk);
		rd(8'h10);
		chk_pin(d[`ST_RX_AVAIL], 1'b1);
		rchk(`DATA_BUFFER_OFS, 8'h3c);
		// Unread byte waiting and a frame in flight, then master off
		i_peer.send(9'h077, 8, 1);
		wr(`DATA_BUFFER_OFS, 8'h00);
		repeat (40) @(posedge aclk);
		wr(`CONTROL_ONE_OFS, 8'h08);
		repeat (3) @(negedge aclk);
		chk_pin(tx_oe | rx_owned, 1'b0);
		chk_pin(tx_out, 1'b1);
		rchk(`CONTROL_TWO_OFS, 8'h20);
		rchk(`BAUD_DIVISOR_OFS, 8'h01);
		rchk(8'h10, 8'he0);
		repeat (400) @(posedge aclk);
		wr(`CONTROL_ONE_OFS, 8'h88);
		wr(`CONTROL_TWO_OFS, 8'he0);
		tx_chk(8'h42, 9'h042);
		give_verdict;
	end
endmodule // tb_top
